// ===== logic/sdz_top.sv
// Serial audio receiver front end: init hold, 3-wire input, lock/hold, zero flags, APB.
// Assumes pclk is the system clock; serial pins are asynchronous and sampled here.
// Operation
// - System clock must be 128 to 1152 times fs, with rate-dependent limits.
// - Count 1024 system clocks after reset before normal operation.
// - Output mid-scale for the whole initialisation period.
// - After init, lock within the next sample period, then output continuously; the code locks only after three equal frames in a row.
// - Shift serial data on each rising edge of the bit clock.
// - Word clock transitions move the shifted word into holding registers.
// - Hold on word rate change or bit clock stop of three bit periods.
// - Resynchronise by itself within three sample periods when clocks return.
// - Format field picks RJ, I2S or LJ; reset is 24-bit LJ.
// - Samples are two's complement, MSB first.
// - Word clock high is left except I2S, where low is left.
// - Pin variant: only I2S or 16-bit RJ, picked by a pin.
// - Per channel, zero detect after 1024 consecutive zero samples.
// - Zero-detected channel drives its flag active, high by default.
// - Polarity bit inverts both flags; reset is active high.
// - Common bit merges both flags into one; reset is independent.
// - Pin variant drives one common flag high when both channels zero.
//
// Our own choices: the APB interface to the registers and the register addresses.
module sdz_top #(
   parameter int unsigned INIT_CYCLES = sdz_pkg::INIT_CYCLES,
   parameter int unsigned ZERO_WORDS = sdz_pkg::ZERO_WORDS,
   parameter int unsigned PER_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_bit_clock,
   input wire logic word_select_clock,
   input wire logic serial_data,
   input wire logic format_select,
   output logic [23:0] left_sample,
   output logic [23:0] right_sample,
   output logic sample_valid,
   output logic left_zero_flag,
   output logic right_zero_flag,
   output logic common_zero_flag
);

   localparam int unsigned INIT_W = $clog2(INIT_CYCLES + 1);
   localparam int unsigned ZERO_W = $clog2(ZERO_WORDS + 1);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Width of a right-justified word, zero for the MSB-aligned formats
   function automatic logic [4:0] rj_width(input logic [2:0] f);
      unique case (f)
         sdz_pkg::FMT_RJ24: rj_width = 5'h18;
         sdz_pkg::FMT_RJ20: rj_width = 5'h14;
         sdz_pkg::FMT_RJ18: rj_width = 5'h12;
         sdz_pkg::FMT_RJ16: rj_width = 5'h10;
         default: rj_width = 5'h00;
      endcase
   endfunction

   // Supported ratio of system clock to sample rate at this clock
   function automatic logic ratio_ok(input logic [PER_W-1:0] r);
      int unsigned hz;
      hz = sdz_pkg::SYS_CLK_HZ;
      unique case (int'(r))
         128, 192: ratio_ok = 1'b1;
         256, 384, 512: ratio_ok = hz <= 96000 * int'(r);
         768: ratio_ok = hz <= 48000 * int'(r);
         1152: ratio_ok = hz <= 32000 * int'(r);
         default: ratio_ok = 1'b0;
      endcase
   endfunction

   // ----------------------------------------
   // Pin synchronisation and edges
   // ----------------------------------------
   sdz_pkg::sdz_link_s pins;
   logic [3:0] pins_vec;
   logic bclk_q;
   logic wclk_q;

   sdz_pin_sync #(.W(4)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({format_select, serial_data, word_select_clock, serial_bit_clock}),
      .stable(pins_vec)
   );

   assign pins = sdz_pkg::sdz_link_s'(pins_vec);
   wire bck_rise = pins.bclk & ~bclk_q;
   wire word_edge = pins.wclk ^ wclk_q;
   wire frame_start = pins.wclk & ~wclk_q;

   // ----------------------------------------
   // Control register and format decode
   // ----------------------------------------
   sdz_pkg::sdz_ctrl_s ctrl;
   wire [2:0] pin_fmt = pins.fmt_pin ? sdz_pkg::FMT_RJ16 : sdz_pkg::FMT_I2S;
   wire [2:0] eff_fmt = ctrl.pin_mode ? pin_fmt : ctrl.fmt;
   wire [4:0] rj_n = rj_width(eff_fmt);
   wire is_i2s = (eff_fmt == sdz_pkg::FMT_I2S);
   wire left_level = ~is_i2s;
   // I2S data starts one bit after the word clock edge
   wire [5:0] cap_point = is_i2s ? 6'h19 : 6'h18;

   // ----------------------------------------
   // Serial shifter
   // ----------------------------------------
   logic [23:0] shreg;
   logic [23:0] hold_word;
   logic [5:0] bit_cnt;
   wire [23:0] next_shreg = {shreg[22:0], pins.data};
   wire [23:0] rj_word = shreg << (5'h18 - rj_n);
   wire [23:0] new_word = (rj_n != 5'h00) ? rj_word : hold_word;
   wire latch_left = word_edge & (wclk_q == left_level);
   wire latch_right = word_edge & (wclk_q != left_level);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bclk_q <= 1'b0;
         wclk_q <= 1'b0;
         shreg <= '0;
         hold_word <= '0;
         bit_cnt <= '0;
      end
      else
      begin
         bclk_q <= pins.bclk;
         wclk_q <= pins.wclk;
         if (bck_rise)
         begin
            shreg <= next_shreg;
            if ((bit_cnt + 6'h01) == cap_point)
               hold_word <= next_shreg;
         end
         // Word edge wins; the sender keeps bit edges clear of it
         if (word_edge)
            bit_cnt <= '0;
         else if (bck_rise && bit_cnt != 6'h3f)
            bit_cnt <= bit_cnt + 6'h01;
      end
   end

   // ----------------------------------------
   // Init count, clock watch and lock
   // ----------------------------------------
   logic [INIT_W-1:0] init_cnt;
   logic [PER_W-1:0] gap_cnt;
   logic [PER_W-1:0] bck_period;
   logic [PER_W-1:0] frame_bits;
   logic [PER_W-1:0] last_bits;
   logic [PER_W-1:0] frame_clks;
   logic [PER_W-1:0] word_clks;
   logic [1:0] match_cnt;
   wire init_done = (init_cnt == INIT_W'(INIT_CYCLES));
   wire [PER_W+1:0] stall_lim = {2'b00, bck_period} * (PER_W + 2)'(sdz_pkg::STALL_BITS);
   wire stalled = (bck_period != '0) && ({2'b00, gap_cnt} >= stall_lim);
   wire rate_same = (frame_bits == last_bits);
   wire locked = (match_cnt == sdz_pkg::RESYNC_MATCH);
   wire running = init_done & locked;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         init_cnt <= '0;
         gap_cnt <= '0;
         bck_period <= '0;
         frame_bits <= '0;
         last_bits <= '0;
         frame_clks <= '0;
         word_clks <= '0;
         match_cnt <= '0;
      end
      else
      begin
         if (!init_done)
            init_cnt <= init_cnt + INIT_W'(1);
         if (bck_rise)
         begin
            bck_period <= gap_cnt + PER_W'(1);
            gap_cnt <= '0;
         end
         else if (gap_cnt != '1)
            gap_cnt <= gap_cnt + PER_W'(1);
         if (frame_start)
         begin
            last_bits <= frame_bits;
            frame_bits <= '0;
            word_clks <= frame_clks;
            frame_clks <= PER_W'(1);
         end
         else
         begin
            if (bck_rise && frame_bits != '1)
               frame_bits <= frame_bits + PER_W'(1);
            else if (stalled)
               frame_bits <= '0;
            if (frame_clks != '1)
               frame_clks <= frame_clks + PER_W'(1);
         end
         // A stall voids the old bit count, so relock always needs the same fresh frames
         if (stalled)
            last_bits <= '0;
         // Three equal frames in a row restore lock, so resync ends after three frames
         if (stalled)
            match_cnt <= '0;
         else if (frame_start && !rate_same)
            match_cnt <= '0;
         else if (frame_start && !locked)
            match_cnt <= match_cnt + 2'h1;
      end
   end

   // ----------------------------------------
   // Holding registers and sample output
   // ----------------------------------------
   logic [23:0] left_buf;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         left_buf <= sdz_pkg::MID_SCALE;
         left_sample <= sdz_pkg::MID_SCALE;
         right_sample <= sdz_pkg::MID_SCALE;
         sample_valid <= 1'b0;
      end
      else
      begin
         sample_valid <= 1'b0;
         if (latch_left)
            left_buf <= new_word;
         if (!running)
         begin
            left_sample <= sdz_pkg::MID_SCALE;
            right_sample <= sdz_pkg::MID_SCALE;
         end
         else if (latch_right)
         begin
            left_sample <= left_buf;
            right_sample <= new_word;
            sample_valid <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Zero detect and flags
   // ----------------------------------------
   logic zero_l;
   logic zero_r;

   sdz_zero_det #(.CNT_W(ZERO_W), .LIMIT(ZERO_W'(ZERO_WORDS))) u_zero_l (
      .pclk(pclk),
      .presetn(presetn),
      .strobe(latch_left & running),
      .is_zero(new_word == 24'h000000),
      .flag(zero_l)
   );

   sdz_zero_det #(.CNT_W(ZERO_W), .LIMIT(ZERO_W'(ZERO_WORDS))) u_zero_r (
      .pclk(pclk),
      .presetn(presetn),
      .strobe(latch_right & running),
      .is_zero(new_word == 24'h000000),
      .flag(zero_r)
   );

   // Pin variant has no polarity control, so inversion is ignored there
   wire both_zero = zero_l & zero_r;
   wire use_common = ctrl.common | ctrl.pin_mode;
   wire flag_inv = ctrl.invert & ~ctrl.pin_mode;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         left_zero_flag <= 1'b0;
         right_zero_flag <= 1'b0;
         common_zero_flag <= 1'b0;
      end
      else
      begin
         left_zero_flag <= (use_common ? both_zero : zero_l) ^ flag_inv;
         right_zero_flag <= (use_common ? both_zero : zero_r) ^ flag_inv;
         common_zero_flag <= both_zero ^ flag_inv;
      end
   end

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   wire sel_ctrl = (paddr == sdz_pkg::ADDR_CTRL);
   wire sel_stat = (paddr == sdz_pkg::ADDR_STATUS);
   wire sel_left = (paddr == sdz_pkg::ADDR_LEFT);
   wire sel_right = (paddr == sdz_pkg::ADDR_RIGHT);
   wire mapped = sel_ctrl | sel_stat | sel_left | sel_right;
   wire setup = psel & ~penable;
   wire ctrl_wr = psel & penable & pwrite & sel_ctrl;
   logic [31:0] status_word;
   logic [31:0] rd_mux;

   always_comb
   begin
      status_word = '0;
      status_word[sdz_pkg::STAT_INIT_BIT] = init_done;
      status_word[sdz_pkg::STAT_LOCK_BIT] = locked;
      status_word[sdz_pkg::STAT_ZL_BIT] = zero_l;
      status_word[sdz_pkg::STAT_ZR_BIT] = zero_r;
      status_word[sdz_pkg::STAT_RATIO_BIT] = ratio_ok(word_clks);
      status_word[sdz_pkg::STAT_CLKS_LSB +: PER_W] = word_clks;
      rd_mux = '0;
      if (sel_ctrl)
         rd_mux = {26'h0, ctrl};
      else if (sel_stat)
         rd_mux = status_word;
      else if (sel_left)
         rd_mux = {8'h00, left_sample};
      else if (sel_right)
         rd_mux = {8'h00, right_sample};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= sdz_pkg::CTRL_RESET;
         prdata <= '0;
      end
      else
      begin
         if (ctrl_wr)
            ctrl <= pwdata[5:0];
         // Read data is sampled in setup so it stands steady in access
         if (setup && !pwrite)
            prdata <= rd_mux;
      end
   end

   assign pready = psel & penable;
   assign pslverr = psel & penable & ~mapped;

endmodule // sdz_top

// ===== pkg/sdz_pkg.sv
// Shared constants and types for the stereo serial-audio receiver with zero detect.
// Assumes a single 50 MHz system clock and an APB register bus.
package sdz_pkg;

   // ----------------------------------------
   // Widths and timing counts
   // ----------------------------------------
   localparam int unsigned SAMPLE_W = 24;
   localparam int unsigned SYS_CLK_HZ = 50_000_000;
   localparam int unsigned INIT_CYCLES = 1024;
   localparam int unsigned ZERO_WORDS = 1024;
   localparam logic [3:0] STALL_BITS = 4'h3;
   localparam logic [1:0] RESYNC_MATCH = 2'h2;
   localparam logic [23:0] MID_SCALE = 24'h000000;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_LEFT = 8'h08;
   localparam logic [7:0] ADDR_RIGHT = 8'h0c;
   localparam logic [5:0] CTRL_RESET = 6'h05;
   localparam int unsigned STAT_INIT_BIT = 0;
   localparam int unsigned STAT_LOCK_BIT = 1;
   localparam int unsigned STAT_ZL_BIT = 2;
   localparam int unsigned STAT_ZR_BIT = 3;
   localparam int unsigned STAT_RATIO_BIT = 4;
   localparam int unsigned STAT_CLKS_LSB = 16;

   // ----------------------------------------
   // Audio formats
   // ----------------------------------------
   localparam logic [2:0] FMT_RJ24 = 3'h0;
   localparam logic [2:0] FMT_RJ20 = 3'h1;
   localparam logic [2:0] FMT_RJ18 = 3'h2;
   localparam logic [2:0] FMT_RJ16 = 3'h3;
   localparam logic [2:0] FMT_I2S = 3'h4;
   localparam logic [2:0] FMT_LJ24 = 3'h5;

   typedef struct packed {
      logic pin_mode;
      logic common;
      logic invert;
      logic [2:0] fmt;
   } sdz_ctrl_s;

   typedef struct packed {
      logic fmt_pin;
      logic data;
      logic wclk;
      logic bclk;
   } sdz_link_s;

endpackage

// ===== logic/sdz_pin_sync.sv
// Three-stage synchroniser for pins from outside the pclk domain.
// Assumes pins change much slower than pclk; a change counts once stages two and three agree.
module sdz_pin_sync #(
   parameter int unsigned W = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] stable
);

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   wire [W-1:0] agree = s2 ~^ s3;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         stable <= '0;
      end
      else
      begin
         s1 <= async_in;
         s2 <= s1;
         s3 <= s2;
         stable <= (agree & s3) | (~agree & stable);
      end
   end

endmodule // sdz_pin_sync

// ===== logic/sdz_zero_det.sv
// Per-channel run-of-zero-samples counter.
// Assumes one strobe per received sample of this channel.
module sdz_zero_det #(
   parameter int unsigned CNT_W = 11,
   parameter logic [CNT_W-1:0] LIMIT = CNT_W'(sdz_pkg::ZERO_WORDS)
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic strobe,
   input wire logic is_zero,
   output logic flag
);

   logic [CNT_W-1:0] cnt;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt <= '0;
      else if (strobe && !is_zero)
         cnt <= '0;
      else if (strobe && cnt != LIMIT)
         cnt <= cnt + CNT_W'(1);
   end

   assign flag = (cnt == LIMIT);

endmodule // sdz_zero_det

// ===== sim/sdz_sender.sv
// Serial audio sender model: bit clock, word clock and data, one 64-bit frame per call.
// Assumes the bench builds each frame; the bit clock stands still between calls.
module sdz_sender (
   output logic bclk,
   output logic wclk,
   output logic data
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Frame output
   // ----------------------------------------
   initial
   begin
      bclk = 1'b1;
      wclk = 1'b0;
      data = 1'b0;
   end
   task automatic send_frame(input logic [63:0] f, input logic i2s);
      int i;
      for (i = 0; i < 64; i++)
      begin
         bclk <= 1'b0; // 64 bit clocks per word period, 8 system clocks each
         wclk <= (i < 32) ^ i2s; // Left half high, except I2S where it is low
         data <= f[63 - i]; // MSB first, changed away from the sampling edge
         #80;
         bclk <= 1'b1;
         #80;
      end
   endtask
   // A released line must not keep showing the last bit
   task automatic release_data();
      data <= ~data;
   endtask
endmodule // sdz_sender

// ===== sim/sdz_top_properties.sv
// Concurrent checks on the ports of sdz_top.
// Assumes one pclk domain; the flag controls are mirrored from the APB writes seen here.
module sdz_top_properties #(
   parameter int unsigned INIT_CYCLES = 1024
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic serial_bit_clock,
   input wire logic [23:0] left_sample,
   input wire logic [23:0] right_sample,
   input wire logic sample_valid,
   input wire logic common_zero_flag
);
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   logic [15:0] init_cnt;
   logic [7:0] idle_cnt;
   logic [1:0] ctrl_q;
   logic [1:0] ctrl_d;
   wire logic wr_ctrl = psel && penable && pwrite && (paddr == sdz_pkg::ADDR_CTRL);
   wire logic raw_c = common_zero_flag ^ (ctrl_d[0] & ~ctrl_d[1]);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         init_cnt <= 16'h0;
         idle_cnt <= 8'h0;
         ctrl_q <= 2'h0;
         ctrl_d <= 2'h0;
      end
      else
      begin
         if (init_cnt < 16'(INIT_CYCLES))
            init_cnt <= init_cnt + 16'h1;
         idle_cnt <= !$stable(serial_bit_clock) ? 8'h0 : idle_cnt + {7'h0, idle_cnt != 8'hff};
         if (wr_ctrl)
            ctrl_q <= {pwdata[5], pwdata[3]};
         ctrl_d <= ctrl_q; // Flags are registered after the control register
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_nonzero_pair;
      sample_valid && (left_sample != 24'h0 || right_sample != 24'h0);
   endsequence
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_INIT_QUIET: assert property (init_cnt < 16'(INIT_CYCLES) |->
      !sample_valid && left_sample == 24'h0 && right_sample == 24'h0)
      else $error("sample output during init");
   AST_APB_READY: assert property (psel |-> pready == penable)
      else $error("pready not in the access cycle");
   AST_APB_SLVERR: assert property (psel && penable && paddr[1:0] == 2'h0 |->
      pslverr == (paddr > sdz_pkg::ADDR_RIGHT)) else $error("pslverr wrong for address");
   AST_VALID_PULSE: assert property (sample_valid |=> !sample_valid)
      else $error("sample_valid longer than one cycle");
   AST_SAMPLE_WITH_VALID: assert property (($changed(left_sample) && left_sample != 24'h0) ||
      ($changed(right_sample) && right_sample != 24'h0) |-> sample_valid)
      else $error("sample changed without sample_valid");
   AST_BCLK_ALIVE: assert property (sample_valid |-> idle_cnt < 8'h28)
      else $error("sample output while bit clock stalled");
   AST_ZERO_CLEAR: assert property (s_nonzero_pair |-> ##3 !raw_c)
      else $error("common flag not cleared by nonzero sample");
   AST_FLAG_STEADY: assert property ($changed(common_zero_flag) |-> $past(sample_valid) ||
      $past(sample_valid, 2) || $past(sample_valid, 3) || $past(wr_ctrl) || $past(wr_ctrl, 2))
      else $error("zero flag moved without a sample");
endmodule // sdz_top_properties
bind sdz_top sdz_top_properties #(.INIT_CYCLES(INIT_CYCLES)) u_sdz_top_properties (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .serial_bit_clock(serial_bit_clock), .left_sample(left_sample),
   .right_sample(right_sample), .sample_valid(sample_valid),
   .common_zero_flag(common_zero_flag));

// ===== sim/testbench.sv
// Self-checking bench for sdz_top: APB set-up, frames in every format, zero flags.
// Assumes the sender model alone drives the serial pins; bursts are separated by stalls.
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned ZW = 4;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic format_select = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic [23:0] left_sample, right_sample;
   logic pready, pslverr, sample_valid, left_zero_flag, right_zero_flag, common_zero_flag;
   logic bclk, wclk, sdata, er;
   logic [5:0] ctl = sdz_pkg::CTRL_RESET;
   logic [47:0] q[$];
   logic [5:0] zc[4] = '{6'h05, 6'h0d, 6'h15, 6'h3d};
   int num_errors = 0;
   int compares = 0;
   int cl = 0;
   int cr = 0;
   sdz_top #(.INIT_CYCLES(16), .ZERO_WORDS(ZW)) u_sdz_top (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_bit_clock(bclk),
      .word_select_clock(wclk), .serial_data(sdata), .format_select(format_select),
      .left_sample(left_sample), .right_sample(right_sample), .sample_valid(sample_valid),
      .left_zero_flag(left_zero_flag), .right_zero_flag(right_zero_flag),
      .common_zero_flag(common_zero_flag));
   sdz_sender u_sdz_sender (.bclk(bclk), .wclk(wclk), .data(sdata));
   initial
   begin
      forever #10 pclk = ~pclk;
   end
   // ----------------------------------------
   // Tasks and model
   // ----------------------------------------
   task automatic complete_run();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      if (w && a == sdz_pkg::ADDR_CTRL)
         ctl = d[5:0];
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   function automatic logic [31:0] half(input logic [2:0] f, input logic [23:0] s);
      case (f)
         sdz_pkg::FMT_RJ24: half = {8'h0, s};
         sdz_pkg::FMT_RJ20: half = {12'h0, s[23:4]};
         sdz_pkg::FMT_RJ18: half = {14'h0, s[23:6]};
         sdz_pkg::FMT_RJ16: half = {16'h0, s[23:8]};
         sdz_pkg::FMT_I2S: half = {1'b0, s, 7'h0};
         default: half = {s, 8'h0};
      endcase
   endfunction
   // Three lead-in frames give time to lock; the trailing frame's pair is never closed
   task automatic burst(input logic [5:0] c, input int n, input logic z);
      logic [2:0] f;
      logic [23:0] l, r, m;
      int i;
      apb(1'b1, sdz_pkg::ADDR_CTRL, {26'h0, c});
      f = c[5] ? (format_select ? sdz_pkg::FMT_RJ16 : sdz_pkg::FMT_I2S) : c[2:0];
      m = 24'hffffff << ((f == sdz_pkg::FMT_RJ20) ? 4 : (f == sdz_pkg::FMT_RJ18) ? 6 :
         (f == sdz_pkg::FMT_RJ16) ? 8 : 0);
      for (i = 0; i < n + 4; i++)
      begin
         l = (z || i < 3 || i == n + 3) ? 24'h0 : 24'($urandom);
         r = (i < 3 || i == n + 3 || (z && i < 9)) ? 24'h0 : 24'($urandom);
         u_sdz_sender.send_frame({half(f, l), half(f, r)}, f == sdz_pkg::FMT_I2S);
         if (i >= 3 && i < n + 3)
            q.push_back({l & m, r & m});
      end
      u_sdz_sender.release_data();
      // The trailing left half is latched while still locked, so it feeds zero detect
      cl++;
      repeat (60) @(posedge pclk);
      `CHK("pairs_left", 0, q.size())
   endtask
   always @(posedge pclk)
   begin : mon
      logic [47:0] e;
      logic zl, zr, b, inv, com;
      if (sample_valid === 1'b1)
      begin
         e = 48'h0;
         `CHK("pair_expected", 1'b1, q.size() > 0)
         if (q.size() > 0)
         begin
            e = q.pop_front();
            `CHK("left", e[47:24], left_sample)
            `CHK("right", e[23:0], right_sample)
         end
         cl = (e[47:24] == 24'h0) ? cl + 1 : 0;
         cr = (e[23:0] == 24'h0) ? cr + 1 : 0;
         zl = cl >= ZW;
         zr = cr >= ZW;
         b = zl & zr;
         inv = ctl[3] & ~ctl[5];
         com = ctl[4] | ctl[5];
         repeat (3) @(posedge pclk);
         `CHK("zero_left", (com ? b : zl) ^ inv, left_zero_flag)
         `CHK("zero_right", (com ? b : zr) ^ inv, right_zero_flag)
         `CHK("zero_common", b ^ inv, common_zero_flag)
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin : main
      int k;
      void'($urandom(32'h7ed4));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, sdz_pkg::ADDR_STATUS, 32'h0);
      `CHK("init_early", 1'b0, rd[sdz_pkg::STAT_INIT_BIT])
      apb(1'b0, sdz_pkg::ADDR_CTRL, 32'h0);
      `CHK("ctrl_reset", 32'h00000005, rd)
      apb(1'b0, 8'h10, 32'h0);
      `CHK("unmapped_err", 1'b1, er)
      `CHK("unmapped_data", 32'h0, rd)
      for (k = 0; k < 8; k++)
         burst(6'(k), 2, 1'b0);
      for (k = 0; k < 2; k++)
      begin
         format_select <= k[0];
         burst(6'h20, 2, 1'b0);
      end
      foreach (zc[j])
         burst(zc[j], 8, 1'b1);
      apb(1'b0, sdz_pkg::ADDR_STATUS, 32'h0);
      `CHK("init_done", 1'b1, rd[sdz_pkg::STAT_INIT_BIT])
      `CHK("lock_after_stall", 1'b0, rd[sdz_pkg::STAT_LOCK_BIT])
      `CHK("stat_zero_l", cl >= ZW, rd[sdz_pkg::STAT_ZL_BIT])
      `CHK("stat_zero_r", cr >= ZW, rd[sdz_pkg::STAT_ZR_BIT])
      // 64 bit clocks of 160 ns make 512 system clocks a frame
      `CHK("word_clks", 16'h0200, rd[31:16])
      // 512 times a fs near 97.7 kHz lies above the 96 kHz limit of that ratio
      `CHK("ratio_ok", 1'b0, rd[sdz_pkg::STAT_RATIO_BIT])
      complete_run();
   end
   initial
   begin
      #2000000;
      num_errors++;
      complete_run();
   end
endmodule // testbench
